// [src/mu_defs.vh]
`ifndef MU_DEFS_VH
`define MU_DEFS_VH

// ==========================================================
// Register byte offsets
`define MU_ADDR_W 8
`define MU_OFS_UNLOCK 8'h00
`define MU_OFS_CONFIRM 8'h04
`define MU_OFS_IDENT 8'h08
`define MU_OFS_INIT 8'h0C
`define MU_OFS_STATUS 8'h10

// ==========================================================
// Init register fields
`define MU_INIT_GATE 0
`define MU_INIT_PWR 1

// ==========================================================
// Status register fields
`define MU_STS_UNLOCKED 0
`define MU_STS_PWR 1
`define MU_STS_GATE 2
`define MU_STS_SEQERR 3
`define MU_STS_SLEEPOK 4

// ==========================================================
// Values
`define MU_DATA_W 32
`define MU_BYTE_W 8
`define MU_ZERO32 32'h00000000
`define MU_ZERO8 8'h00
`define MU_BUS_IDLE 1'b0

`endif

// [src/mu_unlock.v]
`include "mu_defs.vh"

module mu_unlock #(
    parameter [7:0] UNLOCK_KEY = 8'h5A
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Strobe from the register slave
    input wire port_wr,
    input wire [7:0] port_data,
    // State
    output reg unlocked_q,
    output reg accessed_q
);

    // ==========================================================
    // Key check
    // Unlock is one-way; only reset locks the unit again
    always @(posedge clk) begin
        if (!rst_b) begin
            unlocked_q <= 1'b0;
            accessed_q <= 1'b0;
        end else if (port_wr) begin
            accessed_q <= 1'b1;
            if (port_data == UNLOCK_KEY) begin
                unlocked_q <= 1'b1;
            end
        end
    end

endmodule

// [src/mu_bus_gate.v]
`include "mu_defs.vh"

module mu_bus_gate #(
    parameter DW = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Gate control
    input wire gate_open,
    // Core side
    input wire [DW-1:0] core_dout,
    input wire core_sync,
    // Modem bus pins
    output reg [DW-1:0] modem_bus_dout,
    output reg modem_bus_sync
);

    // ==========================================================
    // Output stage
    // Registered so a closed gate never lets a glitch through
    always @(posedge clk) begin
        if (!rst_b) begin
            modem_bus_dout <= {DW{`MU_BUS_IDLE}};
            modem_bus_sync <= `MU_BUS_IDLE;
        end else if (gate_open) begin
            modem_bus_dout <= core_dout;
            modem_bus_sync <= core_sync;
        end else begin
            modem_bus_dout <= {DW{`MU_BUS_IDLE}};
            modem_bus_sync <= `MU_BUS_IDLE;
        end
    end

endmodule

// [src/mu_power_seq.v]
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`include "mu_defs.vh"

module mu_power_seq #(
    parameter [7:0] UNLOCK_KEY = 8'h5A,
    // Arbitrary value, no meaning beyond this design
    parameter [7:0] CONFIRM_SIG = 8'h3C,
    // Arbitrary value, no meaning beyond this design
    parameter [7:0] UNIT_ID = 8'h51,
    parameter BUS_W = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Avalon-MM slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire avs_waitrequest,
    output reg [31:0] avs_readdata,
    // Core side of the modem bus
    input wire [BUS_W-1:0] core_dout,
    input wire core_sync,
    // Peripheral pins
    output wire peripheral_power_down_n,
    output wire [BUS_W-1:0] modem_bus_dout,
    output wire modem_bus_sync,
    // Power state for the system controller
    output wire sleep_ok
);

    // ==========================================================
    // Bus handshake
    // One wait state on every access gives time to register read data
    reg ack_q;
    wire req;
    wire take;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign take = req & ack_q;

    always @(posedge clk) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else if (take) begin
            ack_q <= 1'b0;
        end else if (req) begin
            ack_q <= 1'b1;
        end
    end

    // ==========================================================
    // Address decode
    function [2:0] dec_sel;
        input [7:0] a;
        begin
            case (a)
                `MU_OFS_UNLOCK: dec_sel = 3'h1;
                `MU_OFS_CONFIRM: dec_sel = 3'h2;
                `MU_OFS_IDENT: dec_sel = 3'h3;
                `MU_OFS_INIT: dec_sel = 3'h4;
                `MU_OFS_STATUS: dec_sel = 3'h5;
                default: dec_sel = 3'h0;
            endcase
        end
    endfunction

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_UNLOCK = 3'h1;
    localparam [2:0] SEL_CONFIRM = 3'h2;
    localparam [2:0] SEL_IDENT = 3'h3;
    localparam [2:0] SEL_INIT = 3'h4;
    localparam [2:0] SEL_STATUS = 3'h5;

    wire [2:0] sel;
    wire unlocked;
    wire lane0;
    wire wr_take;

    assign sel = dec_sel(avs_address);
    assign lane0 = avs_byteenable[0];
    assign wr_take = take & avs_write & lane0;

    // ==========================================================
    // Signature unlock
    // unlock port write
    wire unlock_wr;
    assign unlock_wr = wr_take & (sel == SEL_UNLOCK);

    mu_unlock #(
        .UNLOCK_KEY(UNLOCK_KEY)
    ) u_unlock (
        .clk(clk),
        .rst_b(rst_b),
        .port_wr(unlock_wr),
        .port_data(avs_writedata[7:0]),
        .unlocked_q(unlocked),
        .accessed_q()
    );

    wire open_wr;
    assign open_wr = wr_take & unlocked;

    // ==========================================================
    // Init register and sequencing
    reg gate_q;
    reg gate_d;
    reg pwr_q;
    reg pwr_d;
    reg seq_err_q;
    reg seq_err_d;
    reg viol;
    wire init_wr;
    wire sts_wr;
    wire want_gate;
    wire want_pwr;

    assign init_wr = open_wr & (sel == SEL_INIT);
    assign sts_wr = open_wr & (sel == SEL_STATUS);
    assign want_gate = avs_writedata[`MU_INIT_GATE];
    assign want_pwr = avs_writedata[`MU_INIT_PWR];

    always @* begin
        gate_d = gate_q;
        pwr_d = pwr_q;
        viol = 1'b0;
        if (init_wr) begin
            if (want_gate && !pwr_q) begin
                gate_d = 1'b0;
                viol = 1'b1;
            end else begin
                gate_d = want_gate;
            end
            if (!want_pwr && gate_d) begin
                pwr_d = pwr_q;
                viol = 1'b1;
            end else begin
                pwr_d = want_pwr;
            end
        end
    end

    // Sticky error: a new violation beats a clear in the same cycle
    always @* begin
        seq_err_d = seq_err_q;
        if (sts_wr && avs_writedata[`MU_STS_SEQERR]) begin
            seq_err_d = 1'b0;
        end
        if (viol) begin
            seq_err_d = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            gate_q <= 1'b0;
            pwr_q <= 1'b0;
            seq_err_q <= 1'b0;
        end else begin
            gate_q <= gate_d;
            pwr_q <= pwr_d;
            seq_err_q <= seq_err_d;
        end
    end

    assign peripheral_power_down_n = pwr_q;

    assign sleep_ok = ~gate_q & ~pwr_q;

    // ==========================================================
    // Modem bus gate
    // idle bus while closed
    // Fed the next gate value, so the pins idle on the same edge as the gate closes;
    // otherwise one stale beat could reach a peripheral whose power just dropped
    mu_bus_gate #(
        .DW(BUS_W)
    ) u_gate (
        .clk(clk),
        .rst_b(rst_b),
        .gate_open(gate_d),
        .core_dout(core_dout),
        .core_sync(core_sync),
        .modem_bus_dout(modem_bus_dout),
        .modem_bus_sync(modem_bus_sync)
    );

    // ==========================================================
    // Read path
    reg [31:0] rd_d;
    wire [31:0] status_word;
    wire [31:0] init_word;

    assign status_word = {27'h0000000, sleep_ok, seq_err_q, gate_q, pwr_q, unlocked};
    assign init_word = {30'h00000000, pwr_q, gate_q};

    always @* begin
        rd_d = `MU_ZERO32;
        case (sel)
            SEL_UNLOCK: begin
                rd_d = `MU_ZERO32;
            end
            SEL_CONFIRM: begin
                if (unlocked) begin
                    rd_d = {24'h000000, CONFIRM_SIG};
                end
            end
            SEL_IDENT: begin
                if (unlocked) begin
                    rd_d = {24'h000000, UNIT_ID};
                end
            end
            SEL_INIT: begin
                if (unlocked) begin
                    rd_d = init_word;
                end
            end
            SEL_STATUS: begin
                if (unlocked) begin
                    rd_d = status_word;
                end
            end
            default: begin
                rd_d = `MU_ZERO32;
            end
        endcase
    end

    // Loaded in the wait cycle so data stand at the accepting edge
    always @(posedge clk) begin
        if (!rst_b) begin
            avs_readdata <= `MU_ZERO32;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rd_d;
        end
    end

endmodule

// [sim/mu_codec_model.sv]
module mu_codec_model (
    // Pins from the unit
    input wire clk,
    input wire peripheral_power_down_n,
    input wire [3:0] modem_bus_dout,
    input wire modem_bus_sync,
    // Set once the bus moved while powered off
    output logic fault
);
    timeunit 1ns;
    timeprecision 1ns;
    initial fault = 1'b0;
    always @(posedge clk) begin
        if (!peripheral_power_down_n && (modem_bus_dout !== 4'h0 || modem_bus_sync !== 1'b0)) begin
            fault <= 1'b1;
        end
    end
endmodule

// [sim/mu_chk.sv]
module mu_chk #(
    parameter [7:0] UNLOCK_KEY = 8'h5A,
    parameter [7:0] CONFIRM_SIG = 8'h3C,
    parameter [7:0] UNIT_ID = 8'h51,
    parameter BUS_W = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register bus
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire avs_waitrequest,
    input wire [31:0] avs_readdata,
    // Pins
    input wire peripheral_power_down_n,
    input wire [BUS_W-1:0] modem_bus_dout,
    input wire modem_bus_sync,
    input wire sleep_ok
);
    // ==========
    // Unlock tracking
    logic unl_q;
    wire rd_acc = avs_read && !avs_waitrequest;
    wire wr_acc = avs_write && !avs_waitrequest;
    always @(posedge clk) begin
        if (!rst_b) begin
            unl_q <= 1'b0;
        end else if (wr_acc && avs_address == 8'h00 && avs_byteenable[0]
                     && avs_writedata[7:0] == UNLOCK_KEY) begin
            unl_q <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========
    // Properties
    a_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state count wrong");
    a_locked_zero: assert property (rd_acc && !unl_q |-> avs_readdata == 32'h0)
        else $error("read while locked not zero");
    a_confirm_sig: assert property (rd_acc && unl_q && avs_address == 8'h04 |-> avs_readdata[7:0] == CONFIRM_SIG)
        else $error("confirm value wrong");
    a_ident_val: assert property (rd_acc && unl_q && avs_address == 8'h08 |-> avs_readdata[7:0] == UNIT_ID)
        else $error("identity value wrong");
    a_pin_cause: assert property (!(wr_acc && avs_address == 8'h0C) |=> $stable(peripheral_power_down_n))
        else $error("pin moved without init write");
    a_sleep_pin: assert property (sleep_ok |-> !peripheral_power_down_n && modem_bus_dout == '0 && !modem_bus_sync)
        else $error("sleep allowed with power or bus active");
    a_bus_idle: assert property (!peripheral_power_down_n |-> modem_bus_dout == '0 && !modem_bus_sync)
        else $error("modem bus active while off");
    cover property (rd_acc && unl_q && avs_address == 8'h04);
    cover property ($rose(peripheral_power_down_n));
    cover property ($rose(modem_bus_sync));
endmodule
bind mu_power_seq mu_chk #(.UNLOCK_KEY(UNLOCK_KEY), .CONFIRM_SIG(CONFIRM_SIG), .UNIT_ID(UNIT_ID),
    .BUS_W(BUS_W)) mu_chk_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .peripheral_power_down_n(peripheral_power_down_n),
    .modem_bus_dout(modem_bus_dout), .modem_bus_sync(modem_bus_sync), .sleep_ok(sleep_ok));

// [sim/tb_modem_unit_unlock_and_power_seq.sv]
module tb_modem_unit_unlock_and_power_seq;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [7:0] KEY = 8'h5A;
    // Arbitrary values
    localparam [7:0] SIG = 8'h3C;
    localparam [7:0] UID = 8'h51;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [3:0] core_dout = 4'hA;
    logic core_sync = 1'b1;
    wire avs_waitrequest;
    wire [31:0] avs_readdata;
    wire peripheral_power_down_n;
    wire [3:0] modem_bus_dout;
    wire modem_bus_sync;
    wire sleep_ok;
    wire fault;
    int errors = 0;
    int check_count = 0;
    logic [31:0] rd;
    mu_power_seq #(.UNLOCK_KEY(KEY), .CONFIRM_SIG(SIG), .UNIT_ID(UID), .BUS_W(4)) mu_power_seq_inst (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .core_dout(core_dout),
        .core_sync(core_sync), .peripheral_power_down_n(peripheral_power_down_n),
        .modem_bus_dout(modem_bus_dout), .modem_bus_sync(modem_bus_sync), .sleep_ok(sleep_ok));
    mu_codec_model mu_codec_model_inst (.clk(clk), .peripheral_power_down_n(peripheral_power_down_n),
        .modem_bus_dout(modem_bus_dout), .modem_bus_sync(modem_bus_sync), .fault(fault));
    initial begin
        forever #5 clk = ~clk;
    end
    // ==========
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_locked;
        bus(1, 8'h0C, 32'h2);
        bus(1, 8'h00, 32'h11);
        bus(0, 8'h04, 0); check(rd, 0);
        bus(0, 8'h08, 0); check(rd, 0);
        settle; check(peripheral_power_down_n, 0);
        $display("locked test done");
    endtask
    task automatic t_unlock;
        bus(1, 8'h00, {24'h0, KEY});
        bus(0, 8'h00, 0); check(rd, 0);
        bus(0, 8'h04, 0); check(rd[7:0], SIG);
        bus(0, 8'h08, 0); check(rd[7:0], UID);
        bus(0, 8'h20, 0); check(rd, 0);
        $display("unlock test done");
    endtask
    task automatic t_up;
        // Gate asked together with pin: only the pin may rise
        bus(1, 8'h0C, 32'h3);
        settle; check({modem_bus_sync, modem_bus_dout, peripheral_power_down_n}, 6'h01);
        bus(0, 8'h10, 0); check(rd[4:0], 5'h0B);
        bus(1, 8'h10, 32'h8);
        bus(1, 8'h0C, 32'h3);
        settle; check({modem_bus_sync, modem_bus_dout}, {core_sync, core_dout});
        bus(0, 8'h10, 0); check(rd[4:0], 5'h07);
        $display("power up test done");
    endtask
    task automatic t_down;
        // Pin low while gate open is refused
        bus(1, 8'h0C, 32'h1);
        settle; check(peripheral_power_down_n, 1);
        bus(1, 8'h0C, 32'h2);
        settle; check({modem_bus_sync, modem_bus_dout, sleep_ok}, 6'h00);
        bus(1, 8'h0C, 32'h0);
        settle; check({peripheral_power_down_n, sleep_ok}, 2'h1);
        check(fault, 0);
        $display("power down test done");
    endtask
    task automatic t_reset;
        // Reset in mid-run with the pin high must power down and lock again
        bus(1, 8'h0C, 32'h2);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1; check({peripheral_power_down_n, sleep_ok}, 2'h1);
        bus(0, 8'h04, 0); check(rd, 0);
        $display("reset test done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_locked;
        t_unlock;
        t_up;
        t_down;
        t_reset;
        close_out;
    end
    initial begin
        #20000;
        errors++;
        close_out;
    end
endmodule
